/* dwc_top.sv */
/*
 * debug watchpoint control: watch register, low address and data bytes,
 * read protect status, debug mode flag, sticky event interrupt.
 * assumes the cpu access and register port are synchronous to sys_clk
 * and that the read protect option is a stable level.
 */
// Behaviour
// - read protect blocks setting the break enables
// - bit 7 arms break on writes
// - bit 6 arms break on reads
// - bit 5 requires data equality to break
// - data match matters only with an enable
// - low nibble plus low byte form address
// - status flag shows read protect active
// - status reserved bits read as zero
// - watchpoint break sets debug mode flag
`timescale 1ns/100ps
`include "dwc_params.svh"

module dwc_top
(
	input  wire logic                    sys_clk,        // system clock, 250 MHz
	input  wire logic                    resetn,         // async reset, low active
	input  wire dwc_pkg::dwc_bus_type    bus,            // register port request
	output logic [7:0]                   rdata,          // read data, cycle after read
	input  wire dwc_pkg::dwc_access_type cpu_acc,        // cpu register file access
	input  wire logic                    read_protect_option, // 0 means protected
	input  wire logic                    debug_exit,     // host leaves debug mode
	output logic                         debug_mode_flag,// in debug mode
	output logic                         watch_break,    // break pulse to cpu
	output logic                         irq             // level interrupt
);
	import dwc_pkg::*;

	logic [7:0]            ctl_r;
	logic [7:0]            addr_low_r;
	logic [7:0]            data_r;
	logic [7:0]            rdata_r;
	logic [`DWC_IRQ_W-1:0] irq_stat_r;
	logic [`DWC_IRQ_W-1:0] irq_en_r;
	logic                  irq_r;
	logic                  brk_r;
	dwc_mode_type          mode_r;
	dwc_mode_type          mode_nxt;
	logic [7:0]            ctl_nxt;
	logic [7:0]            rdata_nxt;
	logic [`DWC_IRQ_W-1:0] irq_stat_nxt;

	wire       protect;
	wire       hit;
	wire       wr_ctl;
	wire       wr_low;
	wire       wr_data;
	wire       wr_clr;
	wire       wr_en;
	wire       wr_dbg;
	wire [7:0] status_val;
	wire [7:0] dbg_val;
	wire [7:0] lock_mask;
	wire       ignored;
	wire [`DWC_IRQ_W-1:0] events;

	function automatic logic sel(input logic [`DWC_ADDR_W-1:0] a,
		input logic [`DWC_ADDR_W-1:0] ofs);
		sel = (a == ofs);
	endfunction

	// option bit programmed to 0 means protection is on
	assign protect = ~read_protect_option;

	assign wr_ctl  = bus.wr & sel(bus.addr, `DWC_OFS_CTL);
	assign wr_low  = bus.wr & sel(bus.addr, `DWC_OFS_ADDR_LOW);
	assign wr_data = bus.wr & sel(bus.addr, `DWC_OFS_DATA);
	assign wr_clr  = bus.wr & sel(bus.addr, `DWC_OFS_IRQ_CLR);
	assign wr_en   = bus.wr & sel(bus.addr, `DWC_OFS_IRQ_EN);
	assign wr_dbg  = bus.wr & sel(bus.addr, `DWC_OFS_DBG_CTL);

	// under protection an enable may be cleared but not set
	assign lock_mask = protect ? 8'h1f : 8'hff;
	assign ctl_nxt = wr_ctl ? ((bus.wdata & lock_mask) | (bus.wdata & ctl_r & ~lock_mask))
		: ctl_r;
	assign ignored = wr_ctl & protect & (|(bus.wdata & ~ctl_r & ~lock_mask));

	// bit 4 is stored as written; software keeps it at zero

	assign status_val = {7'h00, protect};
	assign dbg_val = {mode_r == DWC_DEBUG, 7'h00};

	assign events = {ignored, hit};
	// set wins over a clear in the same cycle
	assign irq_stat_nxt = (irq_stat_r & ~(wr_clr ? bus.wdata[`DWC_IRQ_W-1:0] : 2'h0))
		| events;

	// host may leave debug mode via debug control bit 7 written as 0
	assign mode_nxt = hit ? DWC_DEBUG
		: ((debug_exit | (wr_dbg & ~bus.wdata[`DWC_BIT_DEBUG_MODE_FLAG])) ? DWC_RUN : mode_r);

	assign rdata_nxt = !bus.rd ? 8'h00
		: sel(bus.addr, `DWC_OFS_CTL)      ? ctl_r
		: sel(bus.addr, `DWC_OFS_ADDR_LOW) ? addr_low_r
		: sel(bus.addr, `DWC_OFS_DATA)     ? data_r
		: sel(bus.addr, `DWC_OFS_STATUS)   ? status_val
		: sel(bus.addr, `DWC_OFS_IRQ_STAT) ? {6'h00, irq_stat_r}
		: sel(bus.addr, `DWC_OFS_IRQ_EN)   ? {6'h00, irq_en_r}
		: sel(bus.addr, `DWC_OFS_DBG_CTL)  ? dbg_val
		: 8'h00;

	dwc_match u_match
	(
		.sys_clk    (sys_clk),
		.resetn     (resetn),
		.acc        (cpu_acc),
		.wr_en      (ctl_r[`DWC_BIT_WRITE_EN]),
		.rd_en      (ctl_r[`DWC_BIT_READ_EN]),
		.dm_en      (ctl_r[`DWC_BIT_DATA_EN]),
		.watch_addr ({ctl_r[3:0], addr_low_r}),
		.watch_data (data_r),
		.hit        (hit)
	);

	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			ctl_r      <= `DWC_CTL_RESET;
			addr_low_r <= `DWC_BYTE_RESET;
			data_r     <= `DWC_BYTE_RESET;
		end
		else
		begin
			ctl_r <= ctl_nxt;
			if (wr_low)
				addr_low_r <= bus.wdata;
			if (wr_data)
				data_r <= bus.wdata;
		end
	end

	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			irq_stat_r <= 2'h0;
			irq_en_r   <= 2'h0;
			irq_r      <= 1'b0;
			rdata_r    <= 8'h00;
		end
		else
		begin
			irq_stat_r <= irq_stat_nxt;
			if (wr_en)
				irq_en_r <= bus.wdata[`DWC_IRQ_W-1:0];
			irq_r   <= |(irq_stat_nxt & (wr_en ? bus.wdata[`DWC_IRQ_W-1:0] : irq_en_r));
			rdata_r <= rdata_nxt;
		end
	end

	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			mode_r <= DWC_RUN;
			brk_r  <= 1'b0;
		end
		else
		begin
			mode_r <= mode_nxt;
			brk_r  <= hit;
		end
	end

	always_comb
	begin
		case (mode_r)
			DWC_RUN:   debug_mode_flag = 1'b0;
			DWC_DEBUG: debug_mode_flag = 1'b1;
			default:   debug_mode_flag = 1'b0;
		endcase
	end

	assign rdata       = rdata_r;
	assign watch_break = brk_r;
	assign irq         = irq_r;
endmodule

/* dwc_params.svh */
/*
 * constants of the debug watchpoint control block: register offsets,
 * field positions, reset values.
 * assumes inclusion by bare name; definitions only.
 */
`ifndef DWC_PARAMS_SVH
`define DWC_PARAMS_SVH

`define DWC_ADDR_W        4
`define DWC_OFS_CTL       4'h0
`define DWC_OFS_ADDR_LOW  4'h1
`define DWC_OFS_DATA      4'h2
`define DWC_OFS_STATUS    4'h3
`define DWC_OFS_IRQ_STAT  4'h4
`define DWC_OFS_IRQ_CLR   4'h5
`define DWC_OFS_IRQ_EN    4'h6
`define DWC_OFS_DBG_CTL   4'h7

`define DWC_BIT_WRITE_EN  7
`define DWC_BIT_READ_EN   6
`define DWC_BIT_DATA_EN   5
`define DWC_BIT_RSVD      4
`define DWC_BIT_DEBUG_MODE_FLAG   7
`define DWC_BIT_RPFLAG    0
`define DWC_IRQ_BREAK     0
`define DWC_IRQ_IGNORED   1

`define DWC_CTL_RESET     8'h00
`define DWC_BYTE_RESET    8'h00
`define DWC_IRQ_W         2

`endif

/* dwc_pkg.sv */
/*
 * types of the debug watchpoint control block.
 * assumes dwc_params.svh is in the include path.
 */
`include "dwc_params.svh"

package dwc_pkg;
	typedef struct packed
	{
		logic        valid;
		logic        write;
		logic [11:0] addr;
		logic [7:0]  data;
	} dwc_access_type;

	typedef struct packed
	{
		logic [`DWC_ADDR_W-1:0] addr;
		logic [7:0]             wdata;
		logic                   wr;
		logic                   rd;
	} dwc_bus_type;

	typedef enum logic [0:0]
	{
		DWC_RUN   = 1'b0,
		DWC_DEBUG = 1'b1
	} dwc_mode_type;
endpackage

/* dwc_match.sv */
/*
 * registered comparator that decides whether one register file access
 * hits the armed watchpoint.
 * assumes the access and the watch setup are synchronous to sys_clk.
 */
`timescale 1ns/100ps

module dwc_match
	import dwc_pkg::*;
(
	input  wire logic           sys_clk,      // system clock
	input  wire logic           resetn,       // async reset, low active
	input  wire dwc_access_type acc,          // access seen this cycle
	input  wire logic           wr_en,        // break on write armed
	input  wire logic           rd_en,        // break on read armed
	input  wire logic           dm_en,        // data match required
	input  wire logic [11:0]    watch_addr,   // full watched address
	input  wire logic [7:0]     watch_data,   // watched data value
	output logic                hit           // one-cycle hit pulse
);
	wire type_ok;
	wire addr_ok;
	wire data_ok;
	wire hit_nxt;

	assign type_ok = acc.valid & (acc.write ? wr_en : rd_en);
	assign addr_ok = (acc.addr == watch_addr);
	// data match only narrows a hit already enabled by type
	assign data_ok = ~dm_en | (acc.data == watch_data);
	assign hit_nxt = type_ok & addr_ok & data_ok;

	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
			hit <= 1'b0;
		else
			hit <= hit_nxt;
	end
endmodule

/* dwc_sva.sv */
/* port checker for dwc_top.
 * assumes bus and cpu accesses synchronous to sys_clk. */
`timescale 1ns/100ps
module dwc_sva
(
	input wire logic                    sys_clk,             // clock
	input wire logic                    resetn,              // reset
	input wire dwc_pkg::dwc_bus_type    bus,                 // reg port
	input wire logic [7:0]              rdata,               // read data
	input wire dwc_pkg::dwc_access_type cpu_acc,             // cpu access
	input wire logic                    read_protect_option, // protect
	input wire logic                    debug_exit,          // exit
	input wire logic                    debug_mode_flag,     // mode
	input wire logic                    watch_break,         // break
	input wire logic                    irq                  // interrupt
);
	import dwc_pkg::*;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!resetn);
	property p_rdz; !$past(bus.rd) |-> rdata == 8'h00; endproperty
	a_rdz: assert property (p_rdz) else $error("rdata not idle");
	property p_sts; $past(bus.rd) && $past(bus.addr) == 4'h3
		|-> rdata == {7'h00, !$past(read_protect_option)}; endproperty
	a_sts: assert property (p_sts) else $error("status wrong");
	property p_umap; $past(bus.rd) && $past(bus.addr[3]) |-> rdata == 8'h00; endproperty
	a_umap: assert property (p_umap) else $error("unmapped read");
	property p_mode; watch_break |-> debug_mode_flag; endproperty
	a_mode: assert property (p_mode) else $error("break without mode");
	property p_cause; watch_break |-> $past(cpu_acc.valid, 2); endproperty
	a_cause: assert property (p_cause) else $error("break without access");
	property p_rise; $rose(debug_mode_flag) |-> watch_break; endproperty
	a_rise: assert property (p_rise) else $error("mode without break");
	property p_hold; debug_mode_flag && !debug_exit && !(bus.wr && bus.addr == 4'h7)
		|=> debug_mode_flag; endproperty
	a_hold: assert property (p_hold) else $error("mode dropped");
	property p_one; watch_break && !$past(cpu_acc.valid) |=> !watch_break; endproperty
	a_one: assert property (p_one) else $error("break too long");
	c_brk: cover property (watch_break);
	c_exit: cover property ($fell(debug_mode_flag));
	c_irq: cover property (irq);
endmodule

/* dwc_cpu.sv */
/* cpu access path model: one access per request.
 * assumes the bench drives req after clock edges. */
`timescale 1ns/100ps
module dwc_cpu
(
	input wire logic                    sys_clk, // clock
	input wire dwc_pkg::dwc_access_type req,     // requested access
	output dwc_pkg::dwc_access_type     acc      // to the block
);
	import dwc_pkg::*;
	// idle fields churn so stale address or data never looks reusable
	logic [20:0] junk_r = 21'h155555;
	always_ff @(posedge sys_clk)
	begin
		junk_r <= ~junk_r;
	end
	assign acc = req.valid ? req : {1'b0, junk_r};
endmodule

/* dwc_bench.sv */
/* self-checking bench of dwc_top against a behavioural model.
 * assumes dwc_sva and dwc_cpu compiled first. */
`timescale 1ns/100ps
module debug_watchpoint_control_bench;
	import dwc_pkg::*;
	logic sys_clk = 0, resetn = 0, prot = 1, dx = 0, md = 0, dmf, brk, irq;
	dwc_bus_type b = '0;
	dwc_access_type req = '0, acc;
	logic [7:0] rdata;
	logic [31:0] r;
	int miscompares = 0, n_tests = 0, seed = 95562, cyc = 0, m[16];
	dwc_top i_dwc_top(.sys_clk, .resetn, .bus(b), .rdata, .cpu_acc(acc),
		.read_protect_option(prot), .debug_exit(dx), .debug_mode_flag(dmf),
		.watch_break(brk), .irq);
	dwc_cpu i_dwc_cpu(.sys_clk, .req, .acc);
	initial forever #2 sys_clk = ~sys_clk;
	always @(posedge sys_clk) if (++cyc == 6000)
	begin
		miscompares++;
		tally_and_finish;
	end
	task chk(input logic [7:0] s, e);
		n_tests++;
		if (s !== e)
		begin
			miscompares++;
			$display("MISMATCH t=%0t seen %h exp %h", $time, s, e);
		end
	endtask
	function logic [7:0] ex(input logic [3:0] a);
		return a == 3 ? 8'(!prot) : a == 7 ? 8'(md) << 7 : (a > 7 || a == 5) ? 8'h00 : 8'(m[a]);
	endfunction
	task wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge sys_clk) b <= '{a, d, 1'b1, 1'b0};
		@(posedge sys_clk) b.wr <= 0;
		if (a == 0 && !prot)
		begin
			if (d & ~m[0] & 8'he0) m[4] |= 2;
			m[0] = d & 8'h1f | d & m[0];
		end
		else if (a == 5) m[4] &= ~d;
		else if (a == 7 && !d[7]) md = 0;
		else if (a inside {0, 1, 2, 6}) m[a] = d;
	endtask
	task rd(input logic [3:0] a);
		@(posedge sys_clk) b <= '{a, 8'h00, 1'b0, 1'b1};
		@(posedge sys_clk) b.rd <= 0;
		#1 chk(rdata, ex(a));
	endtask
	task cpu(input logic w, input logic [11:0] a, input logic [7:0] d);
		logic h;
		h = a == {m[0][3:0], m[1][7:0]} && (w ? m[0][7] : m[0][6]) && (!m[0][5] || d == m[2]);
		@(posedge sys_clk) req <= '{1'b1, w, a, d};
		@(posedge sys_clk) req.valid <= 0;
		@(posedge sys_clk);
		if (h) m[4] |= 1;
		md |= h;
		#1 chk(brk, h);
		chk(dmf, md);
		chk(irq, |(m[4] & m[6]));
	endtask
	task tally_and_finish;
		$display("checks %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	initial
	begin
		repeat (10) @(posedge sys_clk);
		resetn <= 1;
		for (int a = 0; a < 16; a++) rd(4'(a));
		$display("reset test done");
		for (int k = 0; k < 64; k++)
		begin
			r = $random(seed);
			prot <= k < 48;
			wr(0, 8'h00);
			wr(0, {k[2:0], 1'b0, r[3:0]});
			wr(1, r[11:4]);
			wr(2, r[19:12]);
			wr(6, {7'h00, r[20]});
			wr(4'hc, r[27:20]);
			rd(0);
			cpu(k[5], {m[0][3:0], m[1][7:0]} ^ {11'h000, k[3]}, k[4] ? m[2][7:0] : r[31:24]);
			rd(k[3:0]);
			if (md && k[0]) wr(7, 8'h00);
			else if (md)
			begin
				@(posedge sys_clk) dx <= 1;
				@(posedge sys_clk) dx <= 0;
				md = 0;
			end
			rd(4);
			wr(5, 8'h03);
			$display("test %0d done", k);
		end
		tally_and_finish;
	end
endmodule
bind dwc_top dwc_sva i_dwc_sva(.sys_clk, .resetn, .bus, .rdata, .cpu_acc,
	.read_protect_option, .debug_exit, .debug_mode_flag, .watch_break, .irq);
